/* rtl/smsp_port.sv */
// Master/slave synchronous serial port with double-buffered transmit and receive.
`timescale 1ns/100ps
module smsp_port (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Configuration.
  input  wire logic        module_enable,
  input  wire logic        master_mode,
  input  wire logic        word_width_select,
  input  wire logic        clock_idle_polarity,
  input  wire logic        clock_edge_select,
  input  wire logic        select_pin_enable,
  input  wire logic        serial_out_disable,
  input  wire logic [1:0]  primary_prescale,
  input  wire logic [2:0]  secondary_prescale,
  input  wire logic        sleep_req,
  input  wire logic        xfer_done_irq_enable,
  // Buffer access.
  input  wire logic        buf_wr_en,
  input  wire logic [15:0] buf_wr_data,
  input  wire logic        buf_rd_en,
  output logic      [15:0] shared_xfer_buffer,
  // Status and flag clears.
  input  wire logic        irq_flag_clear,
  input  wire logic        overflow_clear,
  output logic             xfer_done_irq_flag,
  output logic             xfer_done_irq,
  output logic             rx_overflow_flag,
  output logic             rx_full,
  output logic             tx_full,
  output logic             busy,
  // Serial pins.
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             serial_out_oe,
  input  wire logic        shift_clock_pin_in,
  output logic             shift_clock_pin_out,
  output logic             shift_clock_pin_oe,
  input  wire logic        slave_select_n_pin
);

  smsp_pkg::smsp_state_type state_reg;
  smsp_pkg::smsp_state_type state_next;

  logic [15:0] serial_shift_reg;
  logic [15:0] serial_shift_next;
  logic [15:0] tx_holding_buffer;
  logic [3:0]  bit_cnt_reg;
  logic [3:0]  bit_cnt_next;
  logic [4:0]  edge_cnt_reg;
  logic [4:0]  edge_cnt_next;
  logic        sck_active_reg;
  logic        sck_active_next;
  logic        sr_loaded_reg;
  logic        sr_loaded_next;
  logic        out_bit_next;
  logic        sck_prev_reg;
  logic        ss_prev_reg;
  logic [2:0]  pins_sync;
  logic        sin_s;
  logic        sck_s;
  logic        ss_s;
  logic        half_tick;
  logic        master_run;
  logic        lead_m;
  logic        trail_m;
  logic        lead_s;
  logic        trail_s;
  logic        lead_ev;
  logic        trail_ev;
  logic        select_ok;
  logic        ss_rise;
  logic        abort;
  logic        active_ok;
  logic        sample_ev;
  logic        shift_ev;
  logic [3:0]  last_bit;
  logic        word_done;
  logic [15:0] new_word;
  logic        can_direct;
  logic        direct_load;
  logic        queue_load;
  logic        rx_accept;
  logic        rx_drop;
  logic [4:0]  last_edge;
  logic        msb_now;
  logic        msb_tx;
  logic        msb_wr;
  logic        irq_flag_next;

  smsp_sync #(
    .W (3)
  ) u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .async_in ({serial_in_pin, shift_clock_pin_in, slave_select_n_pin}),
    .sync_out (pins_sync)
  );

  assign sin_s = pins_sync[2];
  assign sck_s = pins_sync[1];
  assign ss_s  = pins_sync[0];

  assign master_run = (state_reg == smsp_pkg::SMSP_RUN);

  smsp_prescale u_prescale (
    .core_clk           (core_clk),
    .arst_n             (arst_n),
    .run                (master_run),
    .primary_prescale   (primary_prescale),
    .secondary_prescale (secondary_prescale),
    .half_tick          (half_tick)
  );

  // Edge events: leading means idle to active, trailing means active to idle.
  assign lead_m   = master_run && half_tick && !sck_active_reg;
  assign trail_m  = master_run && half_tick && sck_active_reg;
  assign lead_s   = (sck_s != clock_idle_polarity) && (sck_prev_reg == clock_idle_polarity);
  assign trail_s  = (sck_s == clock_idle_polarity) && (sck_prev_reg != clock_idle_polarity);
  assign lead_ev  = master_mode ? lead_m : lead_s;
  assign trail_ev = master_mode ? trail_m : trail_s;

  assign select_ok = !select_pin_enable || !ss_s;
  assign ss_rise   = !master_mode && select_pin_enable && ss_s && !ss_prev_reg;
  assign abort     = sleep_req || !module_enable || ss_rise;
  assign active_ok = module_enable && !sleep_req && !rx_overflow_flag && (master_mode || select_ok);

  // With edge select set, data changes on the trailing edge and is sampled on the leading one.
  assign sample_ev = active_ok && (clock_edge_select ? lead_ev : trail_ev);
  assign shift_ev  = active_ok && (clock_edge_select ? trail_ev : lead_ev);

  assign last_bit  = word_width_select ? smsp_pkg::LAST_BIT_16 : smsp_pkg::LAST_BIT_8;
  assign last_edge = {last_bit, 1'b1};
  assign word_done = sample_ev && (bit_cnt_reg == last_bit);
  assign new_word  = {serial_shift_reg[14:0], sin_s};

  assign rx_drop   = word_done && rx_full && !buf_rd_en;
  assign rx_accept = word_done && !rx_drop;

  assign can_direct  = !master_run && (bit_cnt_reg == smsp_pkg::CNT_RESET) && !sr_loaded_reg && !tx_full;
  assign direct_load = buf_wr_en && can_direct;
  assign queue_load  = buf_wr_en && !can_direct;

  assign msb_now = word_width_select ? serial_shift_reg[smsp_pkg::MSB_16] : serial_shift_reg[smsp_pkg::MSB_8];
  assign msb_tx  = word_width_select ? tx_holding_buffer[smsp_pkg::MSB_16] : tx_holding_buffer[smsp_pkg::MSB_8];
  assign msb_wr  = word_width_select ? buf_wr_data[smsp_pkg::MSB_16] : buf_wr_data[smsp_pkg::MSB_8];

  // Shift register, bit counter and output bit.
  always_comb begin
    serial_shift_next = serial_shift_reg;
    bit_cnt_next      = bit_cnt_reg;
    sr_loaded_next    = sr_loaded_reg;
    out_bit_next      = serial_out_pin;
    if (abort) begin
      bit_cnt_next = smsp_pkg::CNT_RESET;
    end else if (word_done) begin
      bit_cnt_next = smsp_pkg::CNT_RESET;
      if (tx_full) begin
        serial_shift_next = tx_holding_buffer;
        sr_loaded_next    = 1'b1;
        out_bit_next      = msb_tx;
      end else begin
        serial_shift_next = new_word;
      end
    end else if (sample_ev) begin
      serial_shift_next = new_word;
      bit_cnt_next      = bit_cnt_reg + 4'h1;
      if (!master_mode) begin
        sr_loaded_next = 1'b0;
      end
    end else if (shift_ev) begin
      out_bit_next = msb_now;
    end
    if (direct_load) begin
      serial_shift_next = buf_wr_data;
      sr_loaded_next    = 1'b1;
      out_bit_next      = msb_wr;
    end
    if (master_mode && state_reg == smsp_pkg::SMSP_IDLE && state_next == smsp_pkg::SMSP_RUN) begin
      sr_loaded_next = 1'b0;
    end
  end

  // Master sequencer: two half periods per bit, clock returns to idle at the end.
  always_comb begin
    state_next      = state_reg;
    edge_cnt_next   = edge_cnt_reg;
    sck_active_next = sck_active_reg;
    case (state_reg)
      smsp_pkg::SMSP_IDLE: begin
        if (master_mode && sr_loaded_reg && active_ok) begin
          state_next      = smsp_pkg::SMSP_RUN;
          edge_cnt_next   = 5'h00;
          sck_active_next = 1'b0;
        end
      end
      smsp_pkg::SMSP_RUN: begin
        if (abort || !master_mode) begin
          state_next      = smsp_pkg::SMSP_IDLE;
          sck_active_next = 1'b0;
        end else if (half_tick && !rx_overflow_flag) begin
          sck_active_next = !sck_active_reg;
          edge_cnt_next   = edge_cnt_reg + 5'h01;
          if (edge_cnt_reg == last_edge) begin
            state_next = smsp_pkg::SMSP_IDLE;
          end
        end
      end
      default: begin
        state_next      = smsp_pkg::SMSP_IDLE;
        sck_active_next = 1'b0;
      end
    endcase
  end

  // Done flag: a new completion wins over a clear in the same cycle.
  assign irq_flag_next = word_done || (xfer_done_irq_flag && !irq_flag_clear);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg        <= smsp_pkg::SMSP_IDLE;
      serial_shift_reg <= smsp_pkg::BUF_RESET;
      bit_cnt_reg      <= smsp_pkg::CNT_RESET;
      edge_cnt_reg     <= 5'h00;
      sck_active_reg   <= 1'b0;
      sr_loaded_reg    <= 1'b0;
      sck_prev_reg     <= 1'b0;
      ss_prev_reg      <= 1'b1;
    end else begin
      state_reg        <= state_next;
      serial_shift_reg <= serial_shift_next;
      bit_cnt_reg      <= bit_cnt_next;
      edge_cnt_reg     <= edge_cnt_next;
      sck_active_reg   <= sck_active_next;
      sr_loaded_reg    <= sr_loaded_next;
      sck_prev_reg     <= sck_s;
      ss_prev_reg      <= ss_s;
    end
  end

  // Buffers and flags.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_holding_buffer  <= smsp_pkg::BUF_RESET;
      shared_xfer_buffer <= smsp_pkg::BUF_RESET;
      tx_full            <= 1'b0;
      rx_full            <= 1'b0;
      rx_overflow_flag   <= 1'b0;
      xfer_done_irq_flag <= 1'b0;
      xfer_done_irq      <= 1'b0;
    end else begin
      if (queue_load) begin
        tx_holding_buffer <= buf_wr_data;
      end
      tx_full <= queue_load || (tx_full && !word_done);
      if (rx_accept) begin
        shared_xfer_buffer <= new_word;
      end
      rx_full            <= rx_accept || (rx_full && !buf_rd_en);
      rx_overflow_flag   <= rx_drop || (rx_overflow_flag && !overflow_clear);
      xfer_done_irq_flag <= irq_flag_next;
      xfer_done_irq      <= irq_flag_next && xfer_done_irq_enable;
    end
  end

  // Pin drivers.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_out_pin      <= 1'b0;
      serial_out_oe       <= 1'b0;
      shift_clock_pin_out <= 1'b0;
      shift_clock_pin_oe  <= 1'b0;
      busy                <= 1'b0;
    end else begin
      serial_out_pin      <= out_bit_next;
      serial_out_oe       <= module_enable && !sleep_req && !serial_out_disable
                             && (master_mode || select_ok);
      shift_clock_pin_out <= clock_idle_polarity ^ sck_active_next;
      shift_clock_pin_oe  <= module_enable && master_mode;
      busy                <= (state_next == smsp_pkg::SMSP_RUN) || (bit_cnt_next != smsp_pkg::CNT_RESET);
    end
  end

endmodule

/* rtl/smsp_pkg.sv */
// Shared constants and types of the master/slave serial port.
package smsp_pkg;

  // Word layout of the shift register.
  localparam int unsigned WORD_W = 16;
  localparam logic [3:0] LAST_BIT_8  = 4'h7;
  localparam logic [3:0] LAST_BIT_16 = 4'hF;
  localparam int unsigned MSB_8  = 7;
  localparam int unsigned MSB_16 = 15;

  // Values after reset.
  localparam logic [15:0] BUF_RESET = 16'h0000;
  localparam logic [3:0]  CNT_RESET = 4'h0;

  // Primary prescale divide factors, selected by code 0 to 3.
  localparam logic [6:0] PRI_DIV_0 = 7'h40;
  localparam logic [6:0] PRI_DIV_1 = 7'h10;
  localparam logic [6:0] PRI_DIV_2 = 7'h04;
  localparam logic [6:0] PRI_DIV_3 = 7'h01;

  // Secondary prescale factor is this constant minus the code, giving 8 down to 1.
  localparam logic [3:0] SEC_DIV_BASE = 4'h8;

  // Master sequencer states.
  typedef enum logic [1:0] {
    SMSP_IDLE = 2'b01,
    SMSP_RUN  = 2'b10
  } smsp_state_type;

endpackage

/* rtl/smsp_sync.sv */
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/100ps
module smsp_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset.
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  // Asynchronous input and synchronised output.
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule

/* rtl/smsp_prescale.sv */
// Master shift clock prescaler producing one pulse per half bit period.
`timescale 1ns/100ps
module smsp_prescale (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // Control.
  input  wire logic       run,
  input  wire logic [1:0] primary_prescale,
  input  wire logic [2:0] secondary_prescale,
  // Half period pulse.
  output logic            half_tick
);

  logic [6:0]  pri_div;
  logic [3:0]  sec_div;
  logic [10:0] half_limit;
  logic [10:0] count_reg;
  logic [10:0] count_next;

  assign pri_div = (primary_prescale == 2'h0) ? smsp_pkg::PRI_DIV_0 :
                   (primary_prescale == 2'h1) ? smsp_pkg::PRI_DIV_1 :
                   (primary_prescale == 2'h2) ? smsp_pkg::PRI_DIV_2 : smsp_pkg::PRI_DIV_3;
  assign sec_div = smsp_pkg::SEC_DIV_BASE - {1'b0, secondary_prescale};

  // The port clock is the core clock over two; a shift clock period of
  // primary times secondary port clocks gives a half period of that many core clocks.
  assign half_limit = 11'(pri_div * sec_div) - 11'h001;
  assign half_tick  = run && (count_reg == half_limit);
  assign count_next = (!run || half_tick) ? 11'h000 : count_reg + 11'h001;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= 11'h000;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule

/* sim/smsp_port_monitor.sv */
// Concurrent checks on the serial port flags, buffer and pin enables.
`timescale 1ns/100ps
module smsp_port_monitor (
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        arst_n,
  // Controls.
  input wire logic        module_enable,
  input wire logic        master_mode,
  input wire logic        select_pin_enable,
  input wire logic        serial_out_disable,
  input wire logic        sleep_req,
  input wire logic        xfer_done_irq_enable,
  input wire logic        buf_wr_en,
  input wire logic        buf_rd_en,
  input wire logic        overflow_clear,
  input wire logic        slave_select_n_pin,
  // Outputs.
  input wire logic [15:0] shared_xfer_buffer,
  input wire logic        xfer_done_irq_flag,
  input wire logic        xfer_done_irq,
  input wire logic        rx_overflow_flag,
  input wire logic        rx_full,
  input wire logic        tx_full,
  input wire logic        busy,
  input wire logic        serial_out_oe,
  input wire logic        shift_clock_pin_out
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_idle_write;
    master_mode && module_enable && !sleep_req && !busy && !tx_full && !rx_overflow_flag && buf_wr_en;
  endsequence
  sequence s_deselected;
    (slave_select_n_pin && select_pin_enable && !master_mode) [*4];
  endsequence
  chk_start_on_write: assert property (s_idle_write |-> ##2 busy)
    else $error("master did not start");
  chk_irq_gating: assert property (xfer_done_irq == (xfer_done_irq_flag && $past(xfer_done_irq_enable)))
    else $error("irq differs from flag and enable");
  chk_rx_hold: assert property (rx_full && !buf_rd_en |=> $stable(shared_xfer_buffer))
    else $error("full buffer overwritten");
  chk_ovf_halt: assert property (rx_overflow_flag && !overflow_clear |=> $stable(shift_clock_pin_out))
    else $error("clock moved during overflow");
  chk_read_empties: assert property (buf_rd_en && !xfer_done_irq_flag |=> !rx_full || xfer_done_irq_flag)
    else $error("read left buffer full");
  chk_deselect_quiet: assert property (s_deselected |-> !serial_out_oe)
    else $error("output driven while deselected");
  chk_sdo_release: assert property (serial_out_disable [*2] |-> !serial_out_oe)
    else $error("output driven while disabled");
  chk_queue_write: assert property (buf_wr_en && busy |=> tx_full)
    else $error("write while busy not queued");
endmodule

bind smsp_port smsp_port_monitor u_monitor (
  .core_clk, .arst_n, .module_enable, .master_mode, .select_pin_enable, .serial_out_disable, .sleep_req,
  .xfer_done_irq_enable, .buf_wr_en, .buf_rd_en, .overflow_clear, .slave_select_n_pin, .shared_xfer_buffer,
  .xfer_done_irq_flag, .xfer_done_irq, .rx_overflow_flag, .rx_full, .tx_full, .busy, .serial_out_oe,
  .shift_clock_pin_out
);

/* sim/smsp_partner.sv */
// Behavioural external serial peripheral answering the port in master mode.
`timescale 1ns/100ps
module smsp_partner (
  // Shift clock with the idle level removed, so high means active.
  input  wire logic        act_clk,
  // Serial data lines.
  input  wire logic        mosi,
  output logic             miso,
  // Reply word aligned to bit 15, its load strobe, and the word received.
  input  wire logic [15:0] reply_word,
  input  wire logic        load,
  output logic      [15:0] seen_word
);
  logic [15:0] tx_sr = 16'h0000;
  assign miso = tx_sr[15];
  // Reply bits change on the trailing edge; the filler keeps the line moving afterwards.
  always @(posedge load or negedge act_clk) begin
    if (load) begin
      tx_sr <= reply_word;
    end else begin
      tx_sr <= {tx_sr[14:0], !tx_sr[0]};
    end
  end
  always @(posedge load or posedge act_clk) begin
    if (load) begin
      seen_word <= 16'h0000;
    end else begin
      seen_word <= {seen_word[14:0], mosi};
    end
  end
endmodule

/* sim/spi_master_slave_port_tb_top.sv */
// Self-checking bench for the master/slave serial port.
`timescale 1ns/100ps
module spi_master_slave_port_tb_top;
  logic        core_clk, arst_n, module_enable, master_mode, word_width_select, clock_idle_polarity;
  logic        clock_edge_select, select_pin_enable, serial_out_disable, sleep_req, xfer_done_irq_enable;
  logic        buf_wr_en, buf_rd_en, irq_flag_clear, overflow_clear, ext_sck, slave_select_n_pin, load;
  logic        xfer_done_irq_flag, xfer_done_irq, rx_overflow_flag, rx_full, tx_full, busy;
  logic        serial_in_pin, serial_out_pin, serial_out_oe, shift_clock_pin_out, shift_clock_pin_oe;
  logic [1:0]  primary_prescale;
  logic [2:0]  secondary_prescale;
  logic [15:0] buf_wr_data, shared_xfer_buffer, seen_word, reply, q, mask;
  int          failures = 0;
  int          num_checks = 0;
  int          n;
  // The clock pin follows whichever party drives it; a released data line shows the inverse.
  wire         sck_line = shift_clock_pin_oe ? shift_clock_pin_out : ext_sck;
  wire         sdo_line = serial_out_oe ? serial_out_pin : !serial_out_pin;

  smsp_port DUT (
    .core_clk, .arst_n, .module_enable, .master_mode, .word_width_select, .clock_idle_polarity,
    .clock_edge_select, .select_pin_enable, .serial_out_disable, .primary_prescale, .secondary_prescale,
    .sleep_req, .xfer_done_irq_enable, .buf_wr_en, .buf_wr_data, .buf_rd_en, .shared_xfer_buffer,
    .irq_flag_clear, .overflow_clear, .xfer_done_irq_flag, .xfer_done_irq, .rx_overflow_flag, .rx_full,
    .tx_full, .busy, .serial_in_pin, .serial_out_pin, .serial_out_oe, .shift_clock_pin_in(sck_line),
    .shift_clock_pin_out, .shift_clock_pin_oe, .slave_select_n_pin
  );
  smsp_partner u_peer (
    .act_clk(sck_line ^ clock_idle_polarity), .mosi(sdo_line), .miso(serial_in_pin), .reply_word(reply),
    .load, .seen_word
  );

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] d);
    cyc(1);
    buf_wr_en = 1'b1;
    buf_wr_data = d;
    cyc(1);
    buf_wr_en = 1'b0;
  endtask
  task automatic rd;
    cyc(1);
    q = shared_xfer_buffer;
    buf_rd_en = 1'b1;
    cyc(1);
    buf_rd_en = 1'b0;
  endtask
  // With settle low the task returns once the done flag is cleared, for a port that is meant to stay halted.
  task automatic xfer_wait(input logic settle);
    for (int i = 0; i < 2000 && xfer_done_irq_flag !== 1'b1; i++) cyc(1);
    check(16'(xfer_done_irq_flag), 16'h0001);
    check(16'(xfer_done_irq), 16'(xfer_done_irq_enable));
    irq_flag_clear = 1'b1;
    cyc(1);
    irq_flag_clear = 1'b0;
    if (settle) begin
      for (int i = 0; i < 2000 && busy !== 1'b0; i++) cyc(1);
      check(16'(busy), 16'h0000);
    end
  endtask
  // Word width may only change while the port is disabled, so every setup cycles the enable.
  task automatic setup(input logic m, input logic w, input logic p, input logic [15:0] r);
    module_enable = 1'b0;
    master_mode = m;
    word_width_select = w;
    clock_idle_polarity = p;
    cyc(2);
    module_enable = 1'b1;
    cyc(3);
    reply = r;
    load = 1'b1;
    cyc(1);
    load = 1'b0;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = !core_clk;
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    failures++;
    complete_run;
  end
  initial begin
    {arst_n, module_enable, master_mode, word_width_select, clock_idle_polarity, select_pin_enable} = '0;
    {serial_out_disable, sleep_req, xfer_done_irq_enable, buf_wr_en, buf_rd_en, irq_flag_clear} = '0;
    {overflow_clear, ext_sck, load, buf_wr_data, reply, q, mask} = '0;
    clock_edge_select = 1'b1;
    slave_select_n_pin = 1'b1;
    primary_prescale = 2'h2;
    secondary_prescale = 3'h7;
    cyc(3);
    arst_n = 1'b1;
    // Master transfers in both word widths and both idle levels.
    for (int i = 0; i < 2; i++) begin
      xfer_done_irq_enable = i[0];
      setup(1'b1, i[0], i[0], i ? 16'h5A96 : 16'h3C00);
      wr(i ? 16'hC3A5 : 16'h00A5);
      xfer_wait(1'b1);
      mask = i ? 16'hFFFF : 16'h00FF;
      check(shared_xfer_buffer & mask, i ? 16'h5A96 : 16'h003C);
      check(seen_word & mask, i ? 16'hC3A5 : 16'h00A5);
      check(16'(rx_full), 16'h0001);
      rd;
      check(16'(rx_full), 16'h0000);
      check(16'(shift_clock_pin_out), 16'(clock_idle_polarity));
    end
    // A queued word follows at once; the unread first word causes an overflow.
    setup(1'b1, 1'b1, 1'b1, 16'h1234);
    wr(16'hBEEF);
    cyc(3);
    wr(16'h0F0F);
    check(16'(tx_full), 16'h0001);
    xfer_wait(1'b1);
    xfer_wait(1'b0);
    cyc(20);
    check(16'(busy), 16'h0001);
    check(16'(rx_overflow_flag), 16'h0001);
    check(shared_xfer_buffer, 16'h1234);
    check(seen_word, 16'h0F0F);
    overflow_clear = 1'b1;
    cyc(1);
    overflow_clear = 1'b0;
    rd;
    cyc(40);
    check(16'(busy), 16'h0000);
    check(16'(rx_overflow_flag), 16'h0000);
    check(16'(rx_full), 16'h0000);
    // Slave transfers on bench-made clock pulses, gated by the select pin, in both edge modes.
    // In either mode the bit under test stands on the pin while the clock is active.
    for (int e = 0; e < 2; e++) begin
      clock_edge_select = !e[0];
      setup(1'b0, 1'b0, 1'b0, 16'h0000);
      select_pin_enable = 1'b1;
      wr(16'h0096);
      cyc(4);
      check(16'(serial_out_oe | shift_clock_pin_oe), 16'h0000);
      slave_select_n_pin = 1'b0;
      cyc(4);
      check(16'(serial_out_oe), 16'h0001);
      mask = 16'h0096;
      for (int b = 7; b >= 0; b--) begin
        ext_sck = 1'b1;
        cyc(8);
        check(16'(serial_out_pin), 16'(mask[b]));
        ext_sck = 1'b0;
        cyc(8);
      end
      check(16'(rx_full), 16'h0001);
      xfer_wait(1'b1);
      slave_select_n_pin = 1'b1;
      cyc(5);
      check(16'(serial_out_oe), 16'h0000);
      rd;
    end
    slave_select_n_pin = 1'b0;
    serial_out_disable = 1'b1;
    cyc(4);
    check(16'(serial_out_oe), 16'h0000);
    serial_out_disable = 1'b0;
    slave_select_n_pin = 1'b1;
    // Sleep in mid-transfer aborts it and keeps the buffer.
    primary_prescale = 2'h1;
    secondary_prescale = 3'h6;
    setup(1'b1, 1'b0, 1'b0, 16'h0000);
    wr(16'h0055);
    // Codes 1 and 6 divide by sixteen and two, so each clock phase lasts 32 core cycles.
    for (n = 0; n < 200 && shift_clock_pin_out === clock_idle_polarity; n++) cyc(1);
    for (n = 0; n < 200 && shift_clock_pin_out !== clock_idle_polarity; n++) cyc(1);
    check(16'(n), 16'h0020);
    check(16'(shift_clock_pin_oe), 16'h0001);
    sleep_req = 1'b1;
    cyc(4);
    check(16'(busy), 16'h0000);
    check(16'(xfer_done_irq_flag), 16'h0000);
    check(shared_xfer_buffer, q);
    sleep_req = 1'b0;
    complete_run;
  end
endmodule
